// ### bkpr_pkg.sv
// Package: offsets, field positions, reset values and carriers for the backup register bank
package bkpr_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses on APB)
   // ------------------------------------------------------------
   localparam logic [11:0] BKPR_DATA_BASE   = 12'h000; // Data words 0..15 at 0x000..0x03c
   localparam logic [11:0] BKPR_CAL_OFFSET  = 12'h040; // rtc_calibration_control
   localparam logic [11:0] BKPR_ACC_OFFSET  = 12'h044; // Access/interface control
   localparam logic [11:0] BKPR_STAT_OFFSET = 12'h048; // Calibration status

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BKPR_CAL_LSB     = 0;
   localparam int BKPR_CAL_W       = 7;
   localparam int BKPR_CCO_BIT     = 7;
   localparam int BKPR_POE_BIT     = 8;
   localparam int BKPR_POS_BIT     = 9;
   localparam int BKPR_POWER_INTERFACE_CLOCK_ENABLE_BIT   = 0;
   localparam int BKPR_BACKUP_INTERFACE_CLOCK_ENABLE_BIT   = 1;
   localparam int BKPR_DBP_BIT     = 2;

   // ------------------------------------------------------------
   // Reset values and counts
   // ------------------------------------------------------------
   localparam logic [15:0] BKPR_DATA_RST  = 16'h0000;
   localparam logic [9:0]  BKPR_CTRL_RST  = 10'h000;
   localparam int          BKPR_WIN_BITS  = 20;      // Calibration window of 2^20 pulses
   localparam int          BKPR_DIV_BITS  = 6;       // Divide by 64
   localparam int          BKPR_NWORDS    = 16;

   // Calibration/output control carrier
   typedef struct packed {
      logic       pos;   // pulse_output_select
      logic       poe;   // pulse_output_enable
      logic       calibration_clock_output;   // calibration_clock_output
      logic [6:0] cal;
   } bkpr_ctrl_s;

endpackage

// ### bkpr_mem.sv
// Battery-backed data word storage with registered read data
`timescale 1ns/100ps
module bkpr_mem #(
   parameter int WORDS = 16,
   parameter int AW    = 4
) (
   input  wire logic          clk,
   input  wire logic          bkp_rst_n,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [15:0]   wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [15:0]   rdata
);
   initial
   begin
      if (WORDS > (1 << AW) || WORDS < 1)
         $error("bkpr_mem: WORDS does not fit AW");
   end

   logic [15:0] mem_q [WORDS];

   // --------------------------------------------------------------
   // Storage, cleared only by the backup-domain reset
   // --------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < WORDS; g++)
      begin : g_word
         always_ff @(posedge clk or negedge bkp_rst_n)
         begin
            if (!bkp_rst_n)
               mem_q[g] <= bkpr_pkg::BKPR_DATA_RST; // R03
            else if (we && waddr == AW'(g))
               mem_q[g] <= wdata;
         end
      end
   endgenerate

   // Registered read port
   always_ff @(posedge clk or negedge bkp_rst_n)
   begin
      if (!bkp_rst_n)
         rdata <= 16'h0000;
      else
         rdata <= (int'(raddr) < WORDS) ? mem_q[raddr] : 16'h0000;
   end
endmodule

// ### bkpr_cal.sv
// RTC calibration: pulse skipping per 2^20 window and divide-by-64 clock
`timescale 1ns/100ps
module bkpr_cal #(
   parameter int WIN_BITS = 20,
   parameter int DIV_BITS = 6
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       rtc_tick,
   input  wire logic [6:0] cal,
   output logic            tick_out,
   output logic            div_clk,
   output logic            skip_seen
);
   initial
   begin
      if (WIN_BITS < 8 || DIV_BITS < 2)
         $error("bkpr_cal: window or divider too small");
   end

   logic [WIN_BITS-1:0] win_q;
   logic [6:0]          skip_q;
   logic [DIV_BITS-1:0] div_q;
   wire                 drop = (skip_q < cal);

   // --------------------------------------------------------------
   // Drop the first cal ticks of every 2^20-tick window
   // --------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         win_q     <= '0;
         skip_q    <= 7'h00;
         tick_out  <= 1'b0;
         skip_seen <= 1'b0;
      end
      else
      begin
         tick_out  <= rtc_tick & ~drop;          // R13 R14
         skip_seen <= rtc_tick & drop;
         if (rtc_tick)
         begin
            win_q <= win_q + 1'b1;
            if (win_q == '1)
               skip_q <= 7'h00;                  // New window
            else if (drop)
               skip_q <= skip_q + 7'h01;         // R13
         end
      end
   end

   // RTC clock divided by 64 (toggle every 32 ticks)
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_q   <= '0;
         div_clk <= 1'b0;
      end
      else if (rtc_tick)
      begin
         div_q <= div_q + 1'b1;
         if (div_q[DIV_BITS-2:0] == '1)
            div_clk <= ~div_clk;                 // R11
      end
   end
endmodule

// ### bkpr_top.sv
// Backup-domain register bank: data words, calibration control and pin output over APB
//
// Overview of operation
// R01 - Sixteen 16-bit battery-backed data words
// R02 - Data survives system, power reset, standby
// R03 - Data cleared only by backup-domain reset
// R04 - Backup writes blocked after reset
// R05 - Software enables clocks, then access bit
// R06 - Writes ignored while access disabled
// R07 - Select bit chooses alarm or second
// R08 - Enable bit drives one-tick pulse out
// R09 - Software keeps pin function off then
// R10 - Select/enable cleared only by backup reset
// R11 - Calibration bit outputs RTC clock/64
// R12 - Calibration clock bit cleared at power-off
// R13 - Cal field drops pulses per 2^20
// R14 - Slows RTC 0..121 ppm in steps
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
module bkpr_top #(
   parameter int NWORDS = bkpr_pkg::BKPR_NWORDS
) (
   input  wire logic        pclk,
   input  wire logic        presetn,        // System/power reset
   input  wire logic        bkp_rst_n,      // Backup-domain reset
   input  wire logic        main_supply_on, // Low when main supply is off
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rtc_tick,       // One pclk pulse per RTC clock period
   input  wire logic        rtc_alarm,      // One-tick alarm pulse
   input  wire logic        rtc_second,     // One-tick second pulse
   output logic             rtc_tick_cal,   // Calibrated RTC tick
   output logic             rtc_output_pin,
   output logic             rtc_output_pin_oe
);
   initial
   begin
      if (NWORDS != 16)
         $error("bkpr_top: map holds exactly 16 data words");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   bkpr_pkg::bkpr_ctrl_s ctrl_q;
   logic                 cco_q;
   logic [2:0]           acc_q;
   logic                 rd_ph_q;
   logic [31:0]          rd_mux_q;
   logic                 skip_sticky_q;
   logic [15:0]          mem_rdata;
   logic                 cal_tick;
   logic                 div_clk;
   logic                 skip_seen;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   function automatic logic is_data(input logic [11:0] a);
      is_data = (a[11:6] == bkpr_pkg::BKPR_DATA_BASE[11:6]) && (a[1:0] == 2'b00);
   endfunction

   wire setup_ph   = psel & ~penable;
   wire access_ph  = psel & penable;
   wire hit_data   = is_data(paddr);
   wire hit_cal    = (paddr == bkpr_pkg::BKPR_CAL_OFFSET);
   wire hit_acc    = (paddr == bkpr_pkg::BKPR_ACC_OFFSET);
   wire hit_stat   = (paddr == bkpr_pkg::BKPR_STAT_OFFSET);
   wire hit_any    = hit_data | hit_cal | hit_acc | hit_stat;
   wire access_ok  = &acc_q;                            // R05
   wire wr_commit  = access_ph & pready & pwrite;
   wire lo_lanes   = pstrb[0] & pstrb[1];
   wire wr_data    = wr_commit & hit_data & access_ok & lo_lanes;   // R04 R06
   wire wr_cal     = wr_commit & hit_cal & access_ok & lo_lanes;    // R06
   wire wr_acc     = wr_commit & hit_acc & pstrb[0];

   // ------------------------------------------------------------
   // Data words in the backup domain
   // ------------------------------------------------------------
   bkpr_mem #(
      .WORDS (NWORDS),
      .AW    (4)
   ) u_mem (
      .clk       (pclk),
      .bkp_rst_n (bkp_rst_n),             // R02
      .we        (wr_data),               // R01
      .waddr     (paddr[5:2]),
      .wdata     (pwdata[15:0]),
      .raddr     (paddr[5:2]),
      .rdata     (mem_rdata)
   );

   // ------------------------------------------------------------
   // Calibration and divider
   // ------------------------------------------------------------
   bkpr_cal #(
      .WIN_BITS (bkpr_pkg::BKPR_WIN_BITS),
      .DIV_BITS (bkpr_pkg::BKPR_DIV_BITS)
   ) u_cal (
      .clk       (pclk),
      .rst_n     (bkp_rst_n),
      .rtc_tick  (rtc_tick),
      .cal       (ctrl_q.cal),             // R13
      .tick_out  (cal_tick),
      .div_clk   (div_clk),
      .skip_seen (skip_seen)
   );

   // ------------------------------------------------------------
   // Calibration control: backup-domain bits
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge bkp_rst_n)
   begin
      if (!bkp_rst_n)
      begin
         ctrl_q.pos <= 1'b0;                // R10
         ctrl_q.poe <= 1'b0;                // R10
         ctrl_q.calibration_clock_output <= 1'b0;
         ctrl_q.cal <= 7'h00;
      end
      else if (wr_cal)
      begin
         ctrl_q.pos <= pwdata[bkpr_pkg::BKPR_POS_BIT];
         ctrl_q.poe <= pwdata[bkpr_pkg::BKPR_POE_BIT];
         ctrl_q.calibration_clock_output <= 1'b0;
         ctrl_q.cal <= pwdata[bkpr_pkg::BKPR_CAL_LSB +: bkpr_pkg::BKPR_CAL_W];
      end
   end

   // Calibration clock bit: cleared by main-supply loss, not backup reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cco_q <= 1'b0;
      else if (!main_supply_on)
         cco_q <= 1'b0;                     // R12
      else if (wr_cal)
         cco_q <= pwdata[bkpr_pkg::BKPR_CCO_BIT];
   end

   // ------------------------------------------------------------
   // Access control: cleared by every system reset
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         acc_q <= 3'h0;                     // R04
      else if (wr_acc)
         acc_q <= pwdata[2:0];
   end

   // Sticky flag: a pulse was dropped; set wins over clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         skip_sticky_q <= 1'b0;
      else if (skip_seen)
         skip_sticky_q <= 1'b1;
      else if (wr_commit & hit_stat & pwdata[0])
         skip_sticky_q <= 1'b0;
   end

   // ------------------------------------------------------------
   // APB response: one wait state so memory read data is ready
   // ------------------------------------------------------------
   wire [31:0] rd_sel =
      hit_cal  ? {22'h0, ctrl_q.pos, ctrl_q.poe, cco_q, ctrl_q.cal} :
      hit_acc  ? {29'h0, acc_q} :
      hit_stat ? {30'h0, access_ok, skip_sticky_q} :
                 32'h0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_ph_q  <= 1'b0;
         rd_mux_q <= 32'h0;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         prdata   <= 32'h0;
      end
      else
      begin
         rd_ph_q  <= setup_ph;
         rd_mux_q <= rd_sel;
         pready   <= rd_ph_q;               // Ready in the second access cycle
         pslverr  <= rd_ph_q & ~hit_any;    // Refusal travels with ready
         if (rd_ph_q & ~pwrite)
            prdata <= hit_data ? {16'h0, mem_rdata} : rd_mux_q;
         else if (!access_ph)
            prdata <= 32'h0;
      end
   end

   // ------------------------------------------------------------
   // Pin output: pulse selection or calibration clock
   // ------------------------------------------------------------
   wire pulse_sel = ctrl_q.pos ? rtc_second : rtc_alarm;   // R07

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rtc_output_pin    <= 1'b0;
         rtc_output_pin_oe <= 1'b0;
         rtc_tick_cal      <= 1'b0;
      end
      else
      begin
         rtc_tick_cal      <= cal_tick;
         rtc_output_pin_oe <= cco_q | ctrl_q.poe;           // R08
         if (cco_q)
            rtc_output_pin <= div_clk;                      // R11
         else
            rtc_output_pin <= ctrl_q.poe & pulse_sel;       // R08
      end
   end
endmodule

// ### bkpr_monitor.sv
// Port checker for the backup register bank
`timescale 1ns/100ps
module bkpr_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        rtc_tick,
   input wire logic        rtc_tick_cal
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ------------------------------------------------------------
   // Bus answer
   // ------------------------------------------------------------
   ready_after_setup_a: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("ready missing after setup");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   error_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   unmapped_error_a: assert property (psel && !penable && paddr > 12'h048 |=> ##1 pslverr)
      else $error("unmapped access not refused");
   mapped_no_error_a: assert property (psel && !penable && paddr <= 12'h048 && paddr[1:0] == 2'h0
      |=> ##1 !pslverr)
      else $error("mapped access refused");
   upper_half_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   error_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   // ------------------------------------------------------------
   // Calibrated tick
   // ------------------------------------------------------------
   cal_tick_cause_a: assert property (rtc_tick_cal |-> $past(rtc_tick, 2))
      else $error("calibrated tick without source tick");
   write_seen_c: cover property (pready && pwrite);
   error_seen_c: cover property (pslverr);
   cal_tick_c: cover property (rtc_tick_cal);
endmodule

// ### tb_top.sv
// Self-checking bench for the backup register bank
`timescale 1ns/100ps
module tb_top;
   logic        pclk = 1'h0, presetn = 1'h0, bkp_rst_n = 1'h0, main_supply_on = 1'h1;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, tick_en = 1'h0, last;
   logic        rtc_tick = 1'h0, rtc_alarm = 1'h0, rtc_second = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  pstrb = 4'hf;
   logic        pready, pslverr, rtc_tick_cal, rtc_output_pin, rtc_output_pin_oe, er;
   int          fails = 0, checks_done = 0, n, m, t0, c0, tick_cnt = 0, cal_cnt = 0;

   bkpr_top bkpr_top_inst (.*);

   // Clock and RTC tick source, one tick every second cycle
   always #4 pclk = ~pclk;
   always @(posedge pclk)
   begin
      rtc_tick <= tick_en && !rtc_tick;
      tick_cnt <= tick_cnt + int'(rtc_tick);
      cal_cnt <= cal_cnt + int'(rtc_tick_cal === 1'h1);
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; the request stays up until the next call or idle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'h1 && k < 16);
      rd = prdata;
      er = pslverr;
      if (k >= 16)
         check("bus wait", 32'h0, 32'h1);
   endtask

   task automatic idle(input int c);
      psel <= 1'h0;
      penable <= 1'h0;
      repeat (c) @(posedge pclk);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      check($sformatf("reg %h", a), e, rd);
   endtask

   task automatic sys_reset();
      idle(1);
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
   endtask

   // Fire alarm and/or second and count cycles with the pin driven high
   task automatic pulse(input logic a, input logic s, input int e);
      idle(1);
      rtc_alarm <= a;
      rtc_second <= s;
      @(posedge pclk);
      rtc_alarm <= 1'h0;
      rtc_second <= 1'h0;
      m = 0;
      repeat (8)
      begin
         @(posedge pclk);
         m += int'(rtc_output_pin === 1'h1 && rtc_output_pin_oe === 1'h1);
      end
      check("pin pulse cycles", e, m);
   endtask

   task automatic summarize();
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Watchdog
   initial
   begin
      #40000;
      check("watchdog", 32'h0, 32'h1);
      summarize();
   end

   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      bkp_rst_n <= 1'h1;
      @(posedge pclk);
      rdchk(12'h03c, 32'h0);
      rdchk(12'h040, 32'h0);
      apb(1'h1, 12'h00c, 32'ha5a5);
      apb(1'h1, 12'h044, 32'h3);
      apb(1'h1, 12'h040, 32'h3ff);
      rdchk(12'h00c, 32'h0);
      rdchk(12'h040, 32'h0);
      apb(1'h1, 12'h044, 32'h7);
      for (n = 0; n < 16; n++)
         apb(1'h1, 12'(4 * n), 32'hbeef1200 + n);
      for (n = 0; n < 16; n++)
         rdchk(12'(4 * n), 32'h1200 + n);
      pstrb <= 4'hc;
      apb(1'h1, 12'h000, 32'h9999);
      pstrb <= 4'hf;
      rdchk(12'h000, 32'h1200);
      apb(1'h1, 12'h04c, 32'h1);
      check("error flag", 32'h1, {31'h0, er});
      sys_reset();
      rdchk(12'h014, 32'h1205);
      rdchk(12'h044, 32'h0);
      apb(1'h1, 12'h014, 32'h7777);
      rdchk(12'h014, 32'h1205);
      apb(1'h1, 12'h044, 32'h7);
      apb(1'h1, 12'h040, 32'h305);
      pulse(1'h0, 1'h1, 1);
      apb(1'h1, 12'h040, 32'h105);
      pulse(1'h1, 1'h0, 1);
      check("pin enable", 32'h1, {31'h0, rtc_output_pin_oe});
      pulse(1'h0, 1'h1, 0);
      apb(1'h1, 12'h040, 32'h005);
      pulse(1'h1, 1'h1, 0);
      check("pin enable", 32'h0, {31'h0, rtc_output_pin_oe});
      apb(1'h1, 12'h040, 32'h305);
      sys_reset();
      rdchk(12'h040, 32'h305);
      pulse(1'h0, 1'h1, 1);
      apb(1'h1, 12'h044, 32'h7);
      apb(1'h1, 12'h040, 32'h080);
      idle(1);
      tick_en <= 1'h1;
      last = rtc_output_pin;
      m = 0;
      n = 0;
      for (int c = 0; c < 600 && m < 3; c++)
      begin
         @(posedge pclk);
         if (m == 2 && rtc_tick === 1'h1)
            n++;
         if (rtc_output_pin !== last)
            m++;
         last = rtc_output_pin;
      end
      check("ticks per half period", 32, n);
      tick_en <= 1'h0;
      main_supply_on <= 1'h0;
      @(posedge pclk);
      main_supply_on <= 1'h1;
      rdchk(12'h040, 32'h0);
      idle(4);
      bkp_rst_n <= 1'h0;
      repeat (2) @(posedge pclk);
      bkp_rst_n <= 1'h1;
      rdchk(12'h014, 32'h0);
      apb(1'h1, 12'h040, 32'h5);
      idle(1);
      t0 = tick_cnt;
      c0 = cal_cnt;
      tick_en <= 1'h1;
      repeat (200) @(posedge pclk);
      tick_en <= 1'h0;
      repeat (6) @(posedge pclk);
      check("kept ticks", tick_cnt - t0 - 5, cal_cnt - c0);
      rdchk(12'h048, 32'h3);
      apb(1'h1, 12'h048, 32'h1);
      rdchk(12'h048, 32'h2);
      summarize();
   end
endmodule

bind bkpr_top bkpr_monitor bkpr_monitor_inst (.*);
